/* File: hdl/sli_link_seq.sv */
// Purpose: Transmit-side link initialization sequencer for one lane.
// Assumes: A frame is two ref_clk cycles; one 16-bit word per frame.
// Notes:   The SYSREF offset is the fixed synchronizer latency.
`timescale 1ns/1ps

module sli_link_seq
  import sli_pkg::*;
#(
  parameter int PLL_CYC = PLL_CAL_CYC,
  parameter int CAL_CYC = ADC_CAL_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        sysref,
  input  wire logic        link_sync_request_pins,
  input  wire logic        sync_src_sel,
  input  wire logic        software_sync_request_n,
  input  wire logic [1:0]  power_mode,
  input  wire logic [4:0]  k_m1,
  input  wire logic        scr_en,
  input  wire logic [15:0] sample_in,
  input  wire logic        lane_ready,
  output sli_lane_t        lane_word,
  output logic             lane_valid,
  output sli_status_t      link_status_register
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  sli_state_t       state_r;
  sli_state_t       state_nxt;
  logic [1:0]       raw_in;
  logic [1:0]       meta_r;
  logic [1:0]       sync_r;
  logic             sr_d_r;
  logic             sr_edge;
  logic [2:0]       sync_cnt_r;
  logic             sync_act;
  logic             fph_r;
  logic [4:0]       lmfc_r;
  logic             frame_end;
  logic             lmfc_end;
  logic             live;
  logic             realign;
  logic [1:0]       ila_mf_r;
  logic [CNT_W-1:0] cal_cnt_r;
  logic             cal_done;
  logic             align_r;
  logic             buf_in_rdy;
  logic             step;
  logic             pwr_ok;
  sli_lane_t        gen_w;
  logic             gen_v;

  // A stalled lane freezes the whole sequencer so that no frame is
  // generated that the buffer could not take.
  assign step   = clk_en && buf_in_rdy;
  assign pwr_ok = power_mode == PWR_NORMAL;

  // ---------------------------------------------------------------
  // Input synchronizers
  // ---------------------------------------------------------------
  // [R19] [R20] Sync request source select.
  assign raw_in = {sysref,
                   sync_src_sel ? software_sync_request_n
                                : link_sync_request_pins};

  // [R24] Two-stage synchronizers ahead of qualification.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r[i] <= SYNC_RST[i];
          sync_r[i] <= SYNC_RST[i];
        end else if (step) begin
          meta_r[i] <= raw_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_d_r <= 1'b0;
    end else if (step) begin
      sr_d_r <= sync_r[1];
    end
  end

  assign sr_edge = sync_r[1] && !sr_d_r;

  // ---------------------------------------------------------------
  // Sync request qualification
  // ---------------------------------------------------------------
  // [R5] Count low frames, act only after four.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_cnt_r <= '0;
    end else if (step) begin
      if (sync_r[0]) begin
        sync_cnt_r <= '0;
      end else if (frame_end && sync_cnt_r != SYNC_MIN_FR) begin
        sync_cnt_r <= sync_cnt_r + 1'b1;
      end
    end
  end

  // [R6] The release of the request ends synchronization.
  assign sync_act = sync_cnt_r == SYNC_MIN_FR;

  // ---------------------------------------------------------------
  // Frame clock and LMFC
  // ---------------------------------------------------------------
  assign frame_end = fph_r == FPH_LAST;
  assign lmfc_end  = frame_end && lmfc_r >= k_m1;
  assign live      = state_r == ST_PLL || state_r == ST_CGS ||
                     state_r == ST_ILA || state_r == ST_DATA;

  // [R13] Realign only when both clocks are off.
  // [R16] SYSREF during converter calibration is not expected, and ignored.
  assign realign = live && sr_edge && !frame_end && !lmfc_end;

  // [R1] [R3] Counters free-run and reload on realignment.
  // [R18] Sleep and power-down hold the default phase.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fph_r  <= FPH_ZERO;
      lmfc_r <= LMFC_ZERO;
    end else if (step) begin
      if (realign || state_r == ST_SLEEP || state_r == ST_PDN) begin
        fph_r  <= FPH_ZERO;
        lmfc_r <= LMFC_ZERO;
      end else begin
        fph_r <= frame_end ? FPH_ZERO : fph_r + 1'b1;
        if (lmfc_end) begin
          lmfc_r <= LMFC_ZERO;
        end else if (frame_end) begin
          lmfc_r <= lmfc_r + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Calibration timer
  // ---------------------------------------------------------------
  // [R10] Converter then PLL calibration durations.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_cnt_r <= '0;
    end else if (step) begin
      if (state_nxt != state_r) begin
        cal_cnt_r <= '0;
      end else if (state_r == ST_CAL || state_r == ST_PLL) begin
        cal_cnt_r <= cal_cnt_r + 1'b1;
      end
    end
  end

  assign cal_done = (state_r == ST_CAL)
                  ? cal_cnt_r == CNT_W'(CAL_CYC - 1)
                  : cal_cnt_r == CNT_W'(PLL_CYC - 1);

  // ---------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------
  // [R22] Power modes touch no configuration inputs here.
  always_comb begin
    state_nxt = state_r;
    if (power_mode == PWR_SLEEP) begin
      state_nxt = ST_SLEEP;
    end else if (!pwr_ok) begin
      state_nxt = ST_PDN;
    end else if (realign) begin
      // [R2] [R14] [R15] Break link, recalibrate PLL.
      state_nxt = ST_PLL;
    end else begin
      case (state_r)
        // [R21] Power-down exit runs converter calibration.
        ST_PDN: state_nxt = ST_CAL;
        // [R18] Sleep exit goes straight to PLL calibration.
        ST_SLEEP: state_nxt = ST_PLL;
        ST_CAL: begin
          if (cal_done) begin
            state_nxt = ST_PLL;
          end
        end
        ST_PLL: begin
          if (cal_done) begin
            state_nxt = ST_CGS;
          end
        end
        // [R7] [R11] Leave K28.5 at LMFC boundary.
        ST_CGS: begin
          if (lmfc_end && !sync_act) begin
            state_nxt = ST_ILA;
          end
        end
        ST_ILA: begin
          if (sync_act) begin
            state_nxt = ST_CGS;
          end else if (lmfc_end && ila_mf_r == ILA_LAST) begin
            // [R8] [R9] Four multiframes then data.
            state_nxt = ST_DATA;
          end
        end
        // [R17] Qualified request breaks the link.
        ST_DATA: begin
          if (sync_act) begin
            state_nxt = ST_CGS;
          end
        end
        default: state_nxt = ST_CAL;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_CAL;
    end else if (step) begin
      state_r <= state_nxt;
    end
  end

  // [R8] Multiframe counter within the alignment sequence.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ila_mf_r <= ILA_FIRST;
    end else if (step) begin
      if (state_r != ST_ILA) begin
        ila_mf_r <= ILA_FIRST;
      end else if (lmfc_end) begin
        ila_mf_r <= ila_mf_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Lane word generation
  // ---------------------------------------------------------------
  assign gen_v = step && frame_end &&
                 (live || state_r == ST_DATA);

  always_comb begin
    gen_w = '0;
    case (state_r)
      // [R4] [R14] K28.5 on both octets.
      ST_PLL, ST_CGS: begin
        gen_w.is_k = KFLAG_BOTH;
        gen_w.data = K285_WORD;
      end
      // [R23] The sequence goes out with scrambling off.
      ST_ILA: begin
        gen_w.ila = 1'b1;
        if (lmfc_r == LMFC_ZERO) begin
          gen_w.is_k = KFLAG_HI;
          gen_w.data = {K280_OCT, 6'h00, ila_mf_r};
        end else if (lmfc_end) begin
          gen_w.is_k = KFLAG_LO;
          gen_w.data = {6'h00, ila_mf_r, K283_OCT};
        end else if (ila_mf_r == ILA_CFG_MF &&
                     lmfc_r == ILA_CFG_FR) begin
          // [R8] Configuration octets in the second multiframe.
          gen_w.data = {2'h0, scr_en, k_m1, 8'h00};
        end else begin
          gen_w.data = {3'h0, lmfc_r, 6'h00, ila_mf_r};
        end
      end
      // [R9] Sampled converter data.
      ST_DATA: begin
        gen_w.scr  = scr_en;
        gen_w.data = sample_in;
      end
      default: gen_w = '0;
    endcase
  end

  sli_skid_buf u_buf (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .en        (clk_en),
    .in_word   (gen_w),
    .in_valid  (gen_v),
    .in_ready  (buf_in_rdy),
    .out_word  (lane_word),
    .out_valid (lane_valid),
    .out_ready (lane_ready)
  );

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  // [R12] Aligned edge only confirms the alignment flag.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      align_r <= 1'b0;
    end else if (step) begin
      if (state_r == ST_SLEEP || state_r == ST_PDN) begin
        align_r <= 1'b0;
      end else if (realign || (live && sr_edge && lmfc_end)) begin
        align_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_status_register <= '0;
    end else if (step) begin
      link_status_register.link     <= state_r == ST_DATA;
      link_status_register.sync     <= sync_act;
      link_status_register.realign  <= realign;
      link_status_register.align    <= align_r;
      link_status_register.pll_lock <= state_r == ST_CGS ||
                                       state_r == ST_ILA ||
                                       state_r == ST_DATA;
      link_status_register.cal_done <= state_r != ST_CAL &&
                                       state_r != ST_PDN;
      link_status_register.clk_rdy  <= state_r != ST_PDN &&
                                       state_r != ST_SLEEP;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // [R4] K28.5 during sync.
  a_cgs_k285: assert property ( // [R4]
    gen_v && state_r == ST_CGS |->
      gen_w.data == K285_WORD && gen_w.is_k == KFLAG_BOTH)
    else $error("K28.5 missing during sync");

  // [R5] Qualified only after low frames.
  a_sync_qual: assert property ( // [R5]
    $rose(sync_act) |-> !$past(sync_r[0]) && $past(frame_end))
    else $error("sync request qualified too early");

  // [R7] ILA start point.
  a_ila_start: assert property ( // [R7]
    step && state_r == ST_CGS && state_nxt == ST_ILA |->
      lmfc_end && !sync_act && pwr_ok)
    else $error("ILA started off boundary");

  // [R8] ILA length.
  a_ila_len: assert property ( // [R8]
    step && state_r == ST_ILA && state_nxt == ST_DATA |->
      ila_mf_r == ILA_LAST && lmfc_end)
    else $error("ILA not four multiframes");

  // [R9] Data holds.
  a_data_hold: assert property ( // [R9]
    step && state_r == ST_DATA && !sync_act && !realign && pwr_ok
      |=> state_r == ST_DATA)
    else $error("data transmission dropped");

  // [R2] Realign breaks link.
  a_realign_brk: assert property ( // [R2]
    step && realign && pwr_ok |=>
      state_r == ST_PLL && lmfc_r == LMFC_ZERO && fph_r == FPH_ZERO)
    else $error("realign did not restart link");

  // [R12] Aligned edge harmless.
  a_sref_ok: assert property ( // [R12]
    step && sr_edge && lmfc_end && state_r == ST_DATA && !sync_act &&
      pwr_ok |=> state_r == ST_DATA && lmfc_r == LMFC_ZERO)
    else $error("aligned SYSREF caused realign");

  // [R15] PLL calibration length.
  a_pll_len: assert property ( // [R15]
    step && state_r == ST_PLL && state_nxt == ST_CGS |->
      cal_cnt_r == CNT_W'(PLL_CYC - 1))
    else $error("PLL calibration cut short");

  // [R18] Sleep exit path.
  a_sleep_exit: assert property ( // [R18]
    $past(state_r) == ST_SLEEP && state_r != ST_SLEEP |->
      state_r == ST_PLL || state_r == ST_PDN)
    else $error("sleep exit skipped PLL calibration");

  // [R23] ILA plain.
  a_ila_plain: assert property ( // [R23]
    gen_v && state_r == ST_ILA |-> !gen_w.scr && gen_w.ila)
    else $error("ILA word marked scrambled");

endmodule // sli_link_seq

/* File: hdl/sli_pkg.sv */
// Purpose: Shared constants and types for the serial link init sequencer.
// Assumes: One frame is two device clock cycles; sampling clock = ref_clk.
// Notes:   Tags below mark the logic that carries each rule.
// Operation
// [R1] Align frame clock, LMFC to SYSREF edges.
// [R2] Any re-alignment breaks the current link.
// [R3] Free-running clocks from power-up, no SYSREF needed.
// [R4] Send K28.5 while sync request held low.
// [R5] Ignore sync requests shorter than 4 frames.
// [R6] Receiver pulls request low, releases after lock.
// [R7] Start ILA at LMFC boundary after release.
// [R8] ILA lasts exactly four multiframes, carries config.
// [R9] After ILA send sample data until broken.
// [R10] After calibration, PLL calibration then K28.5.
// [R11] No request during K28.5: ILA next boundary.
// [R12] Aligned SYSREF edge changes nothing at all; the code still sets the align flag.
// [R13] Realign only when LMFC and frame misaligned.
// [R14] SYSREF reinit sends K28.5 without a request.
// [R15] PLL calibration follows every clock re-alignment.
// [R16] No SYSREF during power-up or calibration.
// [R17] Qualified request in data breaks link now.
// [R18] Sleep exit: default phase, PLL calibration, K28.5.
// [R19] Default request source is the external pins.
// [R20] Source select set: software request used instead.
// [R21] Power-down exit calibrates, sleep exit does not.
// [R22] Power modes leave configuration contents unchanged.
// [R23] ILA is never scrambled.
// [R24] Synchronize selected request before counting length.

package sli_pkg;

  // ---------------------------------------------------------------
  // Timing and counts
  // ---------------------------------------------------------------
  localparam int         ADC_CAL_CYC = 1024;
  localparam int         PLL_CAL_CYC = 153000;
  localparam int         CNT_W       = 18;
  localparam logic       FPH_ZERO    = 1'h0;
  localparam logic       FPH_LAST    = 1'h1;
  localparam logic [4:0] LMFC_ZERO   = 5'h00;
  localparam logic [1:0] ILA_FIRST   = 2'h0;
  localparam logic [1:0] ILA_LAST    = 2'h3;
  localparam logic [1:0] ILA_CFG_MF  = 2'h1;
  localparam logic [4:0] ILA_CFG_FR  = 5'h01;
  localparam logic [2:0] SYNC_MIN_FR = 3'h4;
  localparam logic [1:0] SYNC_RST    = 2'h1;

  // ---------------------------------------------------------------
  // Symbols and modes
  // ---------------------------------------------------------------
  localparam logic [15:0] K285_WORD  = 16'hBCBC;
  localparam logic [7:0]  K280_OCT   = 8'h1C;
  localparam logic [7:0]  K283_OCT   = 8'h7C;
  localparam logic [1:0]  KFLAG_BOTH = 2'h3;
  localparam logic [1:0]  KFLAG_HI   = 2'h2;
  localparam logic [1:0]  KFLAG_LO   = 2'h1;
  localparam logic [1:0]  PWR_NORMAL = 2'h0;
  localparam logic [1:0]  PWR_SLEEP  = 2'h2;

  typedef enum logic [2:0] {
    ST_CAL   = 3'h0,
    ST_PLL   = 3'h1,
    ST_CGS   = 3'h3,
    ST_ILA   = 3'h2,
    ST_DATA  = 3'h6,
    ST_SLEEP = 3'h7,
    ST_PDN   = 3'h5
  } sli_state_t;

  typedef struct packed {
    logic [1:0]  is_k;
    logic        scr;
    logic        ila;
    logic [15:0] data;
  } sli_lane_t;

  typedef struct packed {
    logic link;
    logic sync;
    logic realign;
    logic align;
    logic pll_lock;
    logic cal_done;
    logic clk_rdy;
  } sli_status_t;

endpackage

/* File: hdl/sli_skid_buf.sv */
// Purpose: Two-entry buffer between the sequencer and the lane.
// Assumes: Words are taken on valid and ready high together.
// Notes:   Ready on the input side is low only while the skid slot is full.
`timescale 1ns/1ps

module sli_skid_buf
  import sli_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic en,
  input  sli_lane_t in_word,
  input  wire logic in_valid,
  output logic      in_ready,
  output sli_lane_t out_word,
  output logic      out_valid,
  input  wire logic out_ready
);

  sli_lane_t skid_r;
  logic      skid_v_r;
  logic      push;
  logic      free;

  assign in_ready = !skid_v_r;
  assign push     = in_valid && in_ready;
  assign free     = !out_valid || out_ready;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_word  <= '0;
      out_valid <= 1'b0;
    end else if (en && free) begin
      out_word  <= skid_v_r ? skid_r : in_word;
      out_valid <= skid_v_r || push;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      skid_r   <= '0;
      skid_v_r <= 1'b0;
    end else if (en) begin
      if (skid_v_r && free) begin
        skid_v_r <= 1'b0;
      end else if (push && !free) begin
        skid_r   <= in_word;
        skid_v_r <= 1'b1;
      end
    end
  end

endmodule // sli_skid_buf

/* File: verification/sli_rx_model.sv */
// Purpose: Behavioural lane receiver facing the link sequencer.
// Assumes: A word is taken when lane_valid and lane_ready are both high.
// Notes:   In slow mode it stalls three cycles of four so the skid fills.
`timescale 1ns/1ps

module sli_rx_model
  import sli_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  sli_lane_t lane_word,
  input  wire logic lane_valid,
  input  wire logic slow,
  input  wire logic req_low,
  output logic      lane_ready,
  output logic      sync_pins_n,
  output sli_lane_t rx_word,
  output logic      rx_stb
);
  logic [1:0] pace_r;

  // Request held low while the bench drives req_low high.
  assign sync_pins_n = ~req_low;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pace_r     <= 2'h0;
      lane_ready <= 1'b0;
      rx_word    <= '0;
      rx_stb     <= 1'b0;
    end else begin
      pace_r     <= pace_r + 2'h1;
      lane_ready <= !slow || (pace_r == 2'h2);
      rx_stb     <= lane_valid && lane_ready;
      rx_word    <= lane_word;
    end
  end
endmodule // sli_rx_model

/* File: verification/sli_tb.sv */
// Purpose: Self-checking bench for the link init sequencer.
// Assumes: Short calibration counts; nine frames per multiframe.
// Notes:   Words are judged as the receiver model takes them.
`timescale 1ns/1ps

module testbench
  import sli_pkg::*;
;

  localparam int          PLL_N  = 20;
  localparam logic [15:0] SAMPLE = 16'hA5C3;

  logic        ref_clk;
  logic        arst_n;
  logic        sysref;
  logic        sync_src_sel;
  logic        software_sync_request_n;
  logic [1:0]  power_mode;
  logic        slow;
  logic        req_low;
  logic        lane_ready;
  logic        sync_pins_n;
  logic        lane_valid;
  logic        rx_stb;
  sli_lane_t   lane_word;
  sli_lane_t   rx_word;
  sli_status_t status;
  int          failures;
  int          cmp_count;
  int          cycles;

  sli_link_seq #(.PLL_CYC(PLL_N), .CAL_CYC(8)) i_dut (
    .ref_clk                (ref_clk),
    .arst_n                 (arst_n),
    .clk_en                 (1'b1),
    .sysref                 (sysref),
    .link_sync_request_pins (sync_pins_n),
    .sync_src_sel           (sync_src_sel),
    .software_sync_request_n(software_sync_request_n),
    .power_mode             (power_mode),
    .k_m1                   (5'h08),
    .scr_en                 (1'b1),
    .sample_in              (SAMPLE),
    .lane_ready             (lane_ready),
    .lane_word              (lane_word),
    .lane_valid             (lane_valid),
    .link_status_register   (status)
  );

  sli_rx_model i_rx (
    .ref_clk    (ref_clk),
    .arst_n     (arst_n),
    .lane_word  (lane_word),
    .lane_valid (lane_valid),
    .slow       (slow),
    .req_low    (req_low),
    .lane_ready (lane_ready),
    .sync_pins_n(sync_pins_n),
    .rx_word    (rx_word),
    .rx_stb     (rx_stb)
  );

  // ---------------------------------------------------------------
  // Clock, watchdog and helpers
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // The ceiling is well above the thousand or so cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("Error at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic get_w(output sli_lane_t w);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rx_stb !== 1'b1 && n < 400);
    chk(rx_stb === 1'b1, "no word arrived");
    w = rx_word;
  endtask

  task automatic expect_n(input int n, input logic [1:0] k, input string m);
    sli_lane_t w;
    repeat (n) begin
      get_w(w);
      chk(w.is_k === k, m);
    end
  endtask

  // Skips to the alignment sequence, walks it and counts K28.5 words.
  task automatic run_ila(output int nk);
    sli_lane_t w;
    int        i;
    nk = 0;
    get_w(w);
    while (w.is_k !== 2'h2 && nk < 400) begin
      if (w.is_k === 2'h3) nk++;
      get_w(w);
    end
    chk(w.data[15:8] === 8'h1C && w.ila === 1'b1, "ila start");
    for (i = 1; i < 36; i++) begin
      get_w(w);
      chk(w.ila === 1'b1 && w.scr === 1'b0, "ila flags");
      if (i == 1) chk(w.data === 16'h0100, "ila not on boundary");
      if (i == 10) chk(w.data === 16'h2800, "ila config word");
      if (i == 27) chk(w.data === 16'h1C03, "ila last mf start");
      if (i == 35) chk(w.data === 16'h037C, "ila end word");
    end
    get_w(w);
    chk(w.is_k === 2'h0 && w.data === SAMPLE, "no data after ila");
    chk(w.scr === 1'b1 && status.link === 1'b1, "data flags");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_start();
    int nk;
    slow = 1'b1;
    run_ila(nk);
    chk(nk >= PLL_N / 2, "too few K28.5 at start");
    slow = 1'b0;
  endtask

  task automatic t_sync_short();
    req_low = 1'b1;
    repeat (6) @(negedge ref_clk);
    req_low = 1'b0;
    expect_n(12, 2'h0, "short request broke link");
  endtask

  task automatic t_sync_long();
    sli_lane_t w;
    int        n;
    int        nk;
    req_low = 1'b1;
    n = 0;
    do begin
      get_w(w);
      n++;
    end while (w.is_k !== 2'h3 && n < 12);
    chk(w.is_k === 2'h3, "request did not break link");
    expect_n(10, 2'h3, "not K28.5 under request");
    chk(status.sync === 1'b1, "sync flag not set");
    req_low = 1'b0;
    run_ila(nk);
  endtask

  task automatic t_src_sel();
    sli_lane_t w;
    int        n;
    int        nk;
    sync_src_sel = 1'b1;
    req_low = 1'b1;
    expect_n(12, 2'h0, "pins not ignored");
    software_sync_request_n = 1'b0;
    // Qualification takes four frames, so some data still comes first.
    expect_n(4, 2'h0, "software request acted early");
    n = 0;
    do begin
      get_w(w);
      n++;
    end while (w.is_k !== 2'h3 && n < 12);
    chk(w.is_k === 2'h3, "software request unused");
    expect_n(6, 2'h3, "software request dropped");
    req_low = 1'b0;
    sync_src_sel = 1'b0;
    run_ila(nk);
    software_sync_request_n = 1'b1;
  endtask

  task automatic t_sysref();
    int  nk;
    int  a;
    bit  seen;
    seen = 1'b0;
    // Edges only while the link carries data.
    // An odd spacing of eleven cycles puts each try on the other frame
    // phase, so one of two tries must land off a frame end.
    for (a = 0; a < 4 && !seen; a++) begin
      sysref = 1'b1;
      @(negedge ref_clk);
      sysref = 1'b0;
      repeat (8) begin
        @(negedge ref_clk);
        if (status.realign === 1'b1) seen = 1'b1;
      end
      repeat (2) @(negedge ref_clk);
    end
    chk(seen, "misaligned edge ignored");
    run_ila(nk);
    chk(nk >= PLL_N / 2, "no PLL calibration after realign");
    chk(status.align === 1'b1, "alignment flag not set");
  endtask

  task automatic t_power(input logic [1:0] mode);
    int nk;
    power_mode = mode;
    repeat (40) @(negedge ref_clk);
    chk(status.cal_done === (mode == PWR_SLEEP), "cal flag");
    chk(status.clk_rdy === 1'b0 && status.pll_lock === 1'b0, "awake");
    power_mode = PWR_NORMAL;
    run_ila(nk);
    chk(nk >= PLL_N / 2, "no K28.5 after power mode");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    arst_n = 1'b0;
    sysref = 1'b0;
    sync_src_sel = 1'b0;
    software_sync_request_n = 1'b1;
    power_mode = PWR_NORMAL;
    slow = 1'b0;
    req_low = 1'b0;
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    t_start();
    t_sync_short();
    t_sync_long();
    t_src_sel();
    t_sysref();
    t_power(PWR_SLEEP);
    t_power(2'h1);
    complete_run();
  end
endmodule // testbench
